//--- logic/tcm_axil_slave.sv
// Purpose: AXI4-Lite slave front end, one write and one read at a time
// Assumes: Register file decodes address and answers in the pulse cycle
// Notes:   Write pulse one cycle after both channels taken; read likewise
`timescale 1ns/1ps
`include "tcm_params.svh"

module tcm_axil_slave
    import tcm_pkg::*;
(
    input  wire logic                   sys_clk,
    input  wire logic                   reset,
    input  wire logic                   s_axi_awvalid,
    output logic                        s_axi_awready,
    input  wire logic [`TCM_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                   s_axi_wvalid,
    output logic                        s_axi_wready,
    input  wire logic [31:0]            s_axi_wdata,
    input  wire logic [3:0]             s_axi_wstrb,
    output logic                        s_axi_bvalid,
    input  wire logic                   s_axi_bready,
    output logic [1:0]                  s_axi_bresp,
    input  wire logic                   s_axi_arvalid,
    output logic                        s_axi_arready,
    input  wire logic [`TCM_ADDR_W-1:0] s_axi_araddr,
    output logic                        s_axi_rvalid,
    input  wire logic                   s_axi_rready,
    output logic [31:0]                 s_axi_rdata,
    output logic [1:0]                  s_axi_rresp,
    output logic                        wr_pulse,
    output logic [`TCM_ADDR_W-1:0]      wr_addr,
    output logic [31:0]                 wr_data,
    output logic [3:0]                  wr_strb,
    input  wire logic                   wr_ok,
    output logic                        rd_pulse,
    output logic [`TCM_ADDR_W-1:0]      rd_addr,
    input  wire logic [31:0]            rd_data,
    input  wire logic                   rd_ok
);

    logic                   awready_r, awready_nxt;
    logic                   wready_r, wready_nxt;
    logic                   aw_have_r, aw_have_nxt;
    logic                   w_have_r, w_have_nxt;
    logic [`TCM_ADDR_W-1:0] awaddr_r, awaddr_nxt;
    logic [31:0]            wdata_r, wdata_nxt;
    logic [3:0]             wstrb_r, wstrb_nxt;
    logic                   bvalid_r, bvalid_nxt;
    logic [1:0]             bresp_r, bresp_nxt;
    logic                   arready_r, arready_nxt;
    logic                   rd_pend_r, rd_pend_nxt;
    logic [`TCM_ADDR_W-1:0] araddr_r, araddr_nxt;
    logic                   rvalid_r, rvalid_nxt;
    logic [31:0]            rdata_r, rdata_nxt;
    logic [1:0]             rresp_r, rresp_nxt;

    assign wr_pulse = aw_have_r & w_have_r & ~bvalid_r;
    assign wr_addr  = awaddr_r;
    assign wr_data  = wdata_r;
    assign wr_strb  = wstrb_r;
    assign rd_pulse = rd_pend_r;
    assign rd_addr  = araddr_r;

    always_comb begin
        awready_nxt = awready_r;
        wready_nxt  = wready_r;
        aw_have_nxt = aw_have_r;
        w_have_nxt  = w_have_r;
        awaddr_nxt  = awaddr_r;
        wdata_nxt   = wdata_r;
        wstrb_nxt   = wstrb_r;
        bvalid_nxt  = bvalid_r;
        bresp_nxt   = bresp_r;
        if (s_axi_awvalid && awready_r) begin
            awready_nxt = 1'b0;
            aw_have_nxt = 1'b1;
            awaddr_nxt  = s_axi_awaddr;
        end
        if (s_axi_wvalid && wready_r) begin
            wready_nxt = 1'b0;
            w_have_nxt = 1'b1;
            wdata_nxt  = s_axi_wdata;
            wstrb_nxt  = s_axi_wstrb;
        end
        if (wr_pulse) begin
            bvalid_nxt = 1'b1;
            bresp_nxt  = wr_ok ? `TCM_RESP_OKAY : `TCM_RESP_SLVERR;
        end
        if (bvalid_r && s_axi_bready) begin
            bvalid_nxt  = 1'b0;
            aw_have_nxt = 1'b0;
            w_have_nxt  = 1'b0;
            awready_nxt = 1'b1;
            wready_nxt  = 1'b1;
        end
    end

    always_comb begin
        arready_nxt = arready_r;
        rd_pend_nxt = 1'b0;
        araddr_nxt  = araddr_r;
        rvalid_nxt  = rvalid_r;
        rdata_nxt   = rdata_r;
        rresp_nxt   = rresp_r;
        if (s_axi_arvalid && arready_r) begin
            arready_nxt = 1'b0;
            rd_pend_nxt = 1'b1;
            araddr_nxt  = s_axi_araddr;
        end
        if (rd_pend_r) begin
            rvalid_nxt = 1'b1;
            rdata_nxt  = rd_ok ? rd_data : 32'h0000_0000;
            rresp_nxt  = rd_ok ? `TCM_RESP_OKAY : `TCM_RESP_SLVERR;
        end
        if (rvalid_r && s_axi_rready) begin
            rvalid_nxt  = 1'b0;
            arready_nxt = 1'b1;
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            awready_r <= 1'b1;
            wready_r  <= 1'b1;
            aw_have_r <= 1'b0;
            w_have_r  <= 1'b0;
            awaddr_r  <= '0;
            wdata_r   <= 32'h0000_0000;
            wstrb_r   <= 4'h0;
            bvalid_r  <= 1'b0;
            bresp_r   <= `TCM_RESP_OKAY;
            arready_r <= 1'b1;
            rd_pend_r <= 1'b0;
            araddr_r  <= '0;
            rvalid_r  <= 1'b0;
            rdata_r   <= 32'h0000_0000;
            rresp_r   <= `TCM_RESP_OKAY;
        end else begin
            awready_r <= awready_nxt;
            wready_r  <= wready_nxt;
            aw_have_r <= aw_have_nxt;
            w_have_r  <= w_have_nxt;
            awaddr_r  <= awaddr_nxt;
            wdata_r   <= wdata_nxt;
            wstrb_r   <= wstrb_nxt;
            bvalid_r  <= bvalid_nxt;
            bresp_r   <= bresp_nxt;
            arready_r <= arready_nxt;
            rd_pend_r <= rd_pend_nxt;
            araddr_r  <= araddr_nxt;
            rvalid_r  <= rvalid_nxt;
            rdata_r   <= rdata_nxt;
            rresp_r   <= rresp_nxt;
        end
    end

    assign s_axi_awready = awready_r;
    assign s_axi_wready  = wready_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rdata   = rdata_r;
    assign s_axi_rresp   = rresp_r;

endmodule

//--- logic/tcm_edge_det.sv
// Purpose: Rising and falling edge detector for the channel pin
// Assumes: Pin already synchronous to sys_clk
// Notes:   Previous level tracks the pin in every mode
`timescale 1ns/1ps
`include "tcm_params.svh"

module tcm_edge_det
    import tcm_pkg::*;
(
    input  wire logic sys_clk,
    input  wire logic reset,
    input  wire logic pin_in,
    output logic      rise,
    output logic      fall
);

    logic prev_r;
    logic prev_nxt;

    always_comb begin
        prev_nxt = pin_in;
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            prev_r <= 1'b0;
        end else begin
            prev_r <= prev_nxt;
        end
    end

    assign rise = pin_in & ~prev_r;
    assign fall = ~pin_in & prev_r;

endmodule

//--- logic/tcm_params.svh
// Purpose: Offsets, bit positions, reset values of the timer channel block
// Assumes: 32-bit AXI4-Lite data, 12-bit byte address
// Notes:   Included by the package and every design file
`ifndef TCM_PARAMS_SVH
`define TCM_PARAMS_SVH

`define TCM_ADDR_W       12
`define TCM_CSC_OFFSET   12'h000
`define TCM_UNIT_OFFSET  12'h004

`define TCM_FLAG_BIT     7
`define TCM_IE_BIT       6
`define TCM_MSU_BIT      5
`define TCM_MSL_BIT      4
`define TCM_ELSU_BIT     3
`define TCM_ELSL_BIT     2
`define TCM_CAS_BIT      5

`define TCM_CSC_RESET    8'h00
`define TCM_UNIT_RESET   8'h00

`define TCM_RESP_OKAY    2'h0
`define TCM_RESP_SLVERR  2'h2

`endif

//--- logic/tcm_pkg.sv
// Purpose: Types shared by the timer channel block
// Assumes: Nothing beyond the params header
// Notes:   Mode codes are internal only
`include "tcm_params.svh"

package tcm_pkg;

    typedef enum logic [2:0] {
        TCM_MODE_CAPTURE = 3'b000,
        TCM_MODE_COMPARE = 3'b001,
        TCM_MODE_EDGE_ALIGNED_PWM    = 3'b010,
        TCM_MODE_CENTER_ALIGNED_PWM    = 3'b011
    } tcm_mode_t;

    typedef logic [1:0] tcm_edge_sel_t;

endpackage

//--- logic/tcm_top.sv
// Purpose: One timer channel: event flag, irq enable, mode and pin control
// Assumes: Counter, prescaler and value registers live outside this block
// Notes:   Counter match, direction, wrap and duty limits arrive as inputs
//
// Implementation choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "tcm_params.svh"

module tcm_top
    import tcm_pkg::*;
(
    input  wire logic                   sys_clk,
    input  wire logic                   reset,
    input  wire logic                   s_axi_awvalid,
    output logic                        s_axi_awready,
    input  wire logic [`TCM_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                   s_axi_wvalid,
    output logic                        s_axi_wready,
    input  wire logic [31:0]            s_axi_wdata,
    input  wire logic [3:0]             s_axi_wstrb,
    output logic                        s_axi_bvalid,
    input  wire logic                   s_axi_bready,
    output logic [1:0]                  s_axi_bresp,
    input  wire logic                   s_axi_arvalid,
    output logic                        s_axi_arready,
    input  wire logic [`TCM_ADDR_W-1:0] s_axi_araddr,
    output logic                        s_axi_rvalid,
    input  wire logic                   s_axi_rready,
    output logic [31:0]                 s_axi_rdata,
    output logic [1:0]                  s_axi_rresp,
    input  wire logic                   chan_pin_in,
    input  wire logic                   cnt_match,
    input  wire logic                   cnt_down,
    input  wire logic                   cnt_wrap,
    input  wire logic                   duty_zero,
    input  wire logic                   duty_full,
    output logic                        chan_pin_out,
    output logic                        chan_pin_oe,
    output logic                        chan_irq,
    output logic                        capture_strobe,
    output logic                        coh_reset,
    output logic                        center_align_out
);

    logic                   wr_pulse, rd_pulse;
    logic [`TCM_ADDR_W-1:0] wr_addr, rd_addr;
    logic [31:0]            wr_data, rd_data;
    logic [3:0]             wr_strb;
    logic                   wr_ok, rd_ok;
    logic                   pin_rise, pin_fall;

    logic          flag_r, flag_nxt;
    logic          ie_r, ie_nxt;
    logic          msu_r, msu_nxt;
    logic          msl_r, msl_nxt;
    tcm_edge_sel_t els_r, els_nxt;
    logic          cas_r, cas_nxt;
    logic          armed_r, armed_nxt;
    logic          pin_out_r, pin_out_nxt;
    logic          pin_oe_r, pin_oe_nxt;
    logic          irq_r, irq_nxt;
    logic          cap_r, cap_nxt;
    logic          coh_r, coh_nxt;

    logic          wr_csc, wr_unit, rd_csc, rd_unit;
    logic          clear_ok, ic_evt, cmp_evt, evt, is_pwm, hi_true;
    logic          duty_edge;
    tcm_mode_t     mode;
    logic [7:0]    csc_view;
    logic [`TCM_ADDR_W-1:0] wr_word, rd_word;

    tcm_axil_slave u_bus (
        .sys_clk       (sys_clk),
        .reset         (reset),
        .s_axi_awvalid (s_axi_awvalid),
        .s_axi_awready (s_axi_awready),
        .s_axi_awaddr  (s_axi_awaddr),
        .s_axi_wvalid  (s_axi_wvalid),
        .s_axi_wready  (s_axi_wready),
        .s_axi_wdata   (s_axi_wdata),
        .s_axi_wstrb   (s_axi_wstrb),
        .s_axi_bvalid  (s_axi_bvalid),
        .s_axi_bready  (s_axi_bready),
        .s_axi_bresp   (s_axi_bresp),
        .s_axi_arvalid (s_axi_arvalid),
        .s_axi_arready (s_axi_arready),
        .s_axi_araddr  (s_axi_araddr),
        .s_axi_rvalid  (s_axi_rvalid),
        .s_axi_rready  (s_axi_rready),
        .s_axi_rdata   (s_axi_rdata),
        .s_axi_rresp   (s_axi_rresp),
        .wr_pulse      (wr_pulse),
        .wr_addr       (wr_addr),
        .wr_data       (wr_data),
        .wr_strb       (wr_strb),
        .wr_ok         (wr_ok),
        .rd_pulse      (rd_pulse),
        .rd_addr       (rd_addr),
        .rd_data       (rd_data),
        .rd_ok         (rd_ok)
    );

    tcm_edge_det u_edge (
        .sys_clk (sys_clk),
        .reset   (reset),
        .pin_in  (chan_pin_in),
        .rise    (pin_rise),
        .fall    (pin_fall)
    );

    // Word decode; low address bits ignored
    assign wr_word = {wr_addr[`TCM_ADDR_W-1:2], 2'b00};
    assign rd_word = {rd_addr[`TCM_ADDR_W-1:2], 2'b00};
    assign wr_ok   = (wr_word == `TCM_CSC_OFFSET)
                   | (wr_word == `TCM_UNIT_OFFSET);
    assign rd_ok   = (rd_word == `TCM_CSC_OFFSET)
                   | (rd_word == `TCM_UNIT_OFFSET);
    assign wr_csc  = wr_pulse & (wr_word == `TCM_CSC_OFFSET);
    assign wr_unit = wr_pulse & (wr_word == `TCM_UNIT_OFFSET);
    assign rd_csc  = rd_pulse & (rd_word == `TCM_CSC_OFFSET);
    assign rd_unit = rd_pulse & (rd_word == `TCM_UNIT_OFFSET);

    assign csc_view = {flag_r, ie_r, msu_r, msl_r, els_r, 2'b00};

    always_comb begin
        rd_data = 32'h0000_0000;
        if (rd_csc) begin
            rd_data[7:0] = csc_view;
        end else if (rd_unit) begin
            rd_data[`TCM_CAS_BIT] = cas_r;
        end
    end

    always_comb begin
        if (cas_r) begin
            mode = TCM_MODE_CENTER_ALIGNED_PWM;
        end else if (msu_r) begin
            mode = TCM_MODE_EDGE_ALIGNED_PWM;
        end else if (msl_r) begin
            mode = TCM_MODE_COMPARE;
        end else begin
            mode = TCM_MODE_CAPTURE;
        end
    end

    assign is_pwm    = (mode == TCM_MODE_EDGE_ALIGNED_PWM) | (mode == TCM_MODE_CENTER_ALIGNED_PWM);
    assign hi_true   = (els_r == 2'b10);
    assign duty_edge = duty_zero | duty_full;
    assign ic_evt    = (mode == TCM_MODE_CAPTURE)
                     & ((els_r[0] & pin_rise) | (els_r[1] & pin_fall));
    assign cmp_evt   = (mode != TCM_MODE_CAPTURE) & cnt_match
                     & ~(is_pwm & duty_edge);
    assign evt       = ic_evt | cmp_evt;
    assign clear_ok  = wr_csc & wr_strb[0] & ~wr_data[`TCM_FLAG_BIT]
                     & armed_r & ~evt;

    // Flag and clear handshake; a new event always wins over the clear
    always_comb begin
        flag_nxt  = evt | (flag_r & ~clear_ok);
        armed_nxt = armed_r;
        if (evt) begin
            armed_nxt = 1'b0;
        end else if (rd_csc && flag_r) begin
            armed_nxt = 1'b1;
        end else if (wr_csc) begin
            armed_nxt = 1'b0;
        end
        irq_nxt = flag_nxt & ie_nxt;
        cap_nxt = ic_evt;
        coh_nxt = wr_csc;
    end

    // Control fields from software
    always_comb begin
        ie_nxt  = ie_r;
        msu_nxt = msu_r;
        msl_nxt = msl_r;
        els_nxt = els_r;
        cas_nxt = cas_r;
        if (wr_csc && wr_strb[0]) begin
            ie_nxt  = wr_data[`TCM_IE_BIT];
            msu_nxt = wr_data[`TCM_MSU_BIT];
            msl_nxt = wr_data[`TCM_MSL_BIT];
            els_nxt = wr_data[`TCM_ELSU_BIT:`TCM_ELSL_BIT];
        end
        if (wr_unit && wr_strb[0]) begin
            cas_nxt = wr_data[`TCM_CAS_BIT];
        end
    end

    // Pin action per mode
    always_comb begin
        pin_out_nxt = pin_out_r;
        pin_oe_nxt  = (els_r != 2'b00) & (mode != TCM_MODE_CAPTURE);
        unique case (mode)
            TCM_MODE_CAPTURE: begin
                pin_out_nxt = 1'b0;
            end
            TCM_MODE_COMPARE: begin
                if (cnt_match) begin
                    unique case (els_r)
                        2'b01: pin_out_nxt = ~pin_out_r;
                        2'b10: pin_out_nxt = 1'b0;
                        2'b11: pin_out_nxt = 1'b1;
                        2'b00: pin_out_nxt = pin_out_r;
                    endcase
                end
            end
            TCM_MODE_EDGE_ALIGNED_PWM: begin
                if (duty_zero) begin
                    pin_out_nxt = ~hi_true;
                end else if (duty_full) begin
                    pin_out_nxt = hi_true;
                end else if (cnt_match) begin
                    pin_out_nxt = ~hi_true;
                end else if (cnt_wrap) begin
                    pin_out_nxt = hi_true;
                end
            end
            TCM_MODE_CENTER_ALIGNED_PWM: begin
                if (duty_zero) begin
                    pin_out_nxt = ~hi_true;
                end else if (duty_full) begin
                    pin_out_nxt = hi_true;
                end else if (cnt_match && !cnt_down) begin
                    pin_out_nxt = ~hi_true;
                end else if (cnt_match && cnt_down) begin
                    pin_out_nxt = hi_true;
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            flag_r    <= 1'(`TCM_CSC_RESET >> `TCM_FLAG_BIT);
            ie_r      <= 1'b0;
            msu_r     <= 1'b0;
            msl_r     <= 1'b0;
            els_r     <= 2'b00;
            cas_r     <= 1'b0;
            armed_r   <= 1'b0;
            pin_out_r <= 1'b0;
            pin_oe_r  <= 1'b0;
            irq_r     <= 1'b0;
            cap_r     <= 1'b0;
            coh_r     <= 1'b0;
        end else begin
            flag_r    <= flag_nxt;
            ie_r      <= ie_nxt;
            msu_r     <= msu_nxt;
            msl_r     <= msl_nxt;
            els_r     <= els_nxt;
            cas_r     <= cas_nxt;
            armed_r   <= armed_nxt;
            pin_out_r <= pin_out_nxt;
            pin_oe_r  <= pin_oe_nxt;
            irq_r     <= irq_nxt;
            cap_r     <= cap_nxt;
            coh_r     <= coh_nxt;
        end
    end

    assign chan_pin_out     = pin_out_r;
    assign chan_pin_oe      = pin_oe_r;
    assign chan_irq         = irq_r;
    assign capture_strobe   = cap_r;
    assign coh_reset        = coh_r;
    assign center_align_out = cas_r;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    flag_on_edge_a: assert property (ic_evt |=> flag_r && capture_strobe)
        else $error("capture edge did not set flag");
    flag_on_match_a: assert property (cmp_evt |=> flag_r)
        else $error("compare match did not set flag");
    duty_no_flag_a: assert property (
        (is_pwm && cnt_match && duty_edge && !flag_r) |=> !flag_r)
        else $error("flag set at 0 or 100 percent duty");
    irq_gate_a: assert property (chan_irq == (flag_r && ie_r))
        else $error("irq does not follow flag and enable");
    clear_order_a: assert property (
        $fell(flag_r) |-> $past(armed_r) && $past(wr_csc))
        else $error("flag cleared without read then write");
    restart_hs_a: assert property (
        (armed_r && evt) |=> !armed_r && flag_r)
        else $error("event did not restart clear handshake");
    write_one_a: assert property (
        (flag_r && wr_csc && wr_data[`TCM_FLAG_BIT]) |=> flag_r)
        else $error("writing one changed the flag");
    pin_release_a: assert property ((els_r == 2'b00) |=> !chan_pin_oe)
        else $error("pin not released with edge level 00");
    oc_toggle_a: assert property (
        (mode == TCM_MODE_COMPARE && els_r == 2'b01 && cnt_match)
        |=> chan_pin_out != $past(chan_pin_out))
        else $error("compare toggle missing");
    center_aligned_pwm_down_a: assert property (
        (mode == TCM_MODE_CENTER_ALIGNED_PWM && cnt_match && cnt_down && !duty_edge)
        |=> chan_pin_out == $past(hi_true))
        else $error("center pwm down match action wrong");
    coh_pulse_a: assert property (wr_csc |=> coh_reset ##1 !coh_reset)
        else $error("coherency reset pulse missing");
    reserved_zero_a: assert property (rd_csc |-> rd_data[1:0] == 2'b00)
        else $error("reserved bits not zero");

    cov_clear_c: cover property (armed_r ##1 $fell(flag_r));
    cov_restart_c: cover property (armed_r && evt);
    cov_center_aligned_pwm_c: cover property (mode == TCM_MODE_CENTER_ALIGNED_PWM && cnt_match);
    cov_capture_c: cover property (ic_evt && ie_r);

endmodule

//--- tb/tcm_pin_model.sv
// Purpose: Outside source or load on the channel pin
// Assumes: Source level changes right after a clock edge
// Notes:   Timer drive wins while its enable is high
`timescale 1ns/1ps
module tcm_pin_model (
    input  wire logic src_lvl,
    input  wire logic chan_pin_out,
    input  wire logic chan_pin_oe,
    output logic      pin
);
    assign pin = chan_pin_oe ? chan_pin_out : src_lvl;
endmodule

//--- tb/tcm_tb.sv
// Purpose: Self-checking bench for one timer channel
// Assumes: Counter inputs come from the bench
// Notes:   Pin source kept low until capture is armed
`timescale 1ns/1ps
module tb
    import tcm_pkg::*;
;
    logic        sys_clk = 0;
    logic        reset   = 1;
    logic        awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
    logic [11:0] awa = 0, ara = 0;
    logic [31:0] wd  = 0;
    logic        src = 0, match = 0, down = 0, wrap = 0, dz = 0, df = 0;
    wire         awr, wr_r, bv, arr, rv, pin, pout, poe, irq, cao, cap, coh;
    wire  [1:0]  br, rr;
    wire  [31:0] rdat;
    int          errors = 0;
    int          num_checks = 0;

    always #12.5 sys_clk = ~sys_clk;

    tcm_top uut (.sys_clk(sys_clk), .reset(reset),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa),
        .s_axi_wvalid(wv), .s_axi_wready(wr_r), .s_axi_wdata(wd),
        .s_axi_wstrb(4'hF), .s_axi_bvalid(bv), .s_axi_bready(bry),
        .s_axi_bresp(br), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_araddr(ara), .s_axi_rvalid(rv), .s_axi_rready(rry),
        .s_axi_rdata(rdat), .s_axi_rresp(rr), .chan_pin_in(pin),
        .cnt_match(match), .cnt_down(down), .cnt_wrap(wrap),
        .duty_zero(dz), .duty_full(df), .chan_pin_out(pout),
        .chan_pin_oe(poe), .chan_irq(irq), .capture_strobe(cap),
        .coh_reset(coh), .center_align_out(cao));

    tcm_pin_model pm_i (.src_lvl(src), .chan_pin_out(pout),
        .chan_pin_oe(poe), .pin(pin));

    task automatic chk(string n, logic [31:0] s, logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            errors++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic cyc(int n);
        repeat (n) @(posedge sys_clk);
    endtask

    task automatic wr(logic [11:0] a, logic [31:0] d, logic [1:0] e = 0);
        logic da;
        logic dw;
        da = 0;
        dw = 0;
        awa <= a;
        wd <= d;
        awv <= 1;
        wv <= 1;
        while (!(da && dw)) begin
            @(negedge sys_clk);
            da = da | awr;
            dw = dw | wr_r;
            @(posedge sys_clk);
            if (da) awv <= 0;
            if (dw) wv <= 0;
        end
        bry <= 1;
        do @(negedge sys_clk); while (!bv);
        chk("bresp", 32'(br), 32'(e));
        chk("coh", 32'(coh), 32'(a == 12'h000));
        @(posedge sys_clk);
        bry <= 0;
    endtask

    task automatic rd(logic [11:0] a, logic [7:0] e, logic [1:0] r = 0);
        ara <= a;
        arv <= 1;
        do @(negedge sys_clk); while (!arr);
        @(posedge sys_clk);
        arv <= 0;
        rry <= 1;
        do @(negedge sys_clk); while (!rv);
        chk("rdata", rdat, {24'h0, e});
        chk("rresp", 32'(rr), 32'(r));
        @(posedge sys_clk);
        rry <= 0;
    endtask

    task automatic pulse;
        match <= 1;
        cyc(1);
        match <= 0;
        cyc(3);
    endtask

    task automatic t_reg;
        rd(12'h000, 8'h00);
        rd(12'h004, 8'h00);
        wr(12'h000, 32'hFF);
        rd(12'h000, 8'h7C);
        wr(12'h004, 32'h20);
        chk("center", 32'(cao), 1);
        wr(12'h004, 32'h0);
        wr(12'h000, 32'h0);
        cyc(1);
        chk("oe", 32'(poe), 0);
        wr(12'h010, 32'h1, 2'h2);
        rd(12'h010, 8'h00, 2'h2);
    endtask

    task automatic t_cap;
        wr(12'h000, 32'h44);
        src <= 1;
        cyc(1);
        @(negedge sys_clk);
        chk("cap", 32'(cap), 1);
        cyc(2);
        chk("irq", 32'(irq), 1);
        rd(12'h000, 8'hC4);
        src <= 0;
        cyc(2);
        src <= 1;
        cyc(3);
        wr(12'h000, 32'h44);
        rd(12'h000, 8'hC4);
        wr(12'h000, 32'h44);
        chk("irq", 32'(irq), 0);
        src <= 0;
        cyc(3);
        chk("irq", 32'(irq), 0);
        wr(12'h000, 32'h48);
        src <= 1;
        cyc(3);
        chk("irq", 32'(irq), 0);
        src <= 0;
        cyc(3);
        chk("irq", 32'(irq), 1);
        rd(12'h000, 8'hC8);
        wr(12'h000, 32'h4C);
        chk("irq", 32'(irq), 0);
        src <= 1;
        cyc(3);
        chk("irq", 32'(irq), 1);
    endtask

    task automatic t_cmp;
        logic [1:0] els [3] = '{2'h3, 2'h2, 2'h1};
        for (int i = 0; i < 3; i++) begin
            wr(12'h000, {26'h0, 2'h1, els[i], 2'h0});
            pulse;
            chk("pin", 32'(pout), 32'(els[i] != 2'h2));
        end
        chk("irq", 32'(irq), 0);
        rd(12'h000, 8'h94);
    endtask

    task automatic t_pwm;
        wr(12'h000, 32'h38);
        wrap <= 1;
        cyc(1);
        wrap <= 0;
        cyc(3);
        chk("pin", 32'(pout), 1);
        pulse;
        chk("pin", 32'(pout), 0);
        rd(12'h000, 8'hB8);
        wr(12'h000, 32'h28);
        dz <= 1;
        pulse;
        rd(12'h000, 8'h28);
        dz <= 0;
        wr(12'h000, 32'h24);
        pulse;
        chk("pin", 32'(pout), 1);
        rd(12'h000, 8'hA4);
        wr(12'h000, 32'h24);
        df <= 1;
        pulse;
        chk("pin", 32'(pout), 0);
        rd(12'h000, 8'h24);
        df <= 0;
        wr(12'h004, 32'h20);
        wr(12'h000, 32'h08);
        down <= 1;
        pulse;
        chk("pin", 32'(pout), 1);
        down <= 0;
        pulse;
        chk("pin", 32'(pout), 0);
    endtask

    task automatic print_verdict;
        if (errors == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial begin
        cyc(12);
        reset <= 0;
        cyc(2);
        t_reg;
        t_cap;
        t_cmp;
        t_pwm;
        print_verdict;
    end

    initial begin
        cyc(5000);
        errors++;
        print_verdict;
    end
endmodule
